// File: core/fpli_pkg.sv
// constants and types of the flash program and lock interface
// assumes a single 25 MHz clock that also stands for the oscillator period
package fpli_pkg;

  // mode select codes {port2Bit6, port2Bit7, port3Bit6, port3Bit7}
  localparam logic [3:0] SEL_WRITE_CODE = 4'h7;
  localparam logic [3:0] SEL_READ_CODE  = 4'h3;
  localparam logic [3:0] SEL_LOCK_ONE   = 4'hf;
  localparam logic [3:0] SEL_LOCK_TWO   = 4'hc;
  localparam logic [3:0] SEL_LOCK_THREE = 4'ha;
  localparam logic [3:0] SEL_ERASE      = 4'h8;
  localparam logic [3:0] SEL_SIGNATURE  = 4'h0;

  // write kinds queued to the write engine
  localparam logic [1:0] KIND_CODE  = 2'h0;
  localparam logic [1:0] KIND_LOCK1 = 2'h1;
  localparam logic [1:0] KIND_LOCK2 = 2'h2;
  localparam logic [1:0] KIND_LOCK3 = 2'h3;

  // bit positions in the synchronised pin vector
  localparam int PIN_P37   = 0;
  localparam int PIN_P36   = 1;
  localparam int PIN_P27   = 2;
  localparam int PIN_P26   = 3;
  localparam int PIN_STRAP = 4;
  localparam int PIN_PROGRAM_STROBE_N  = 5;
  localparam int PIN_FETCH = 6;
  localparam int PIN_RST   = 7;
  localparam int PIN_ADDR  = 8;
  localparam int PIN_FIXED = 16;

  localparam int ADDR_W_DEF = 12;
  localparam logic [11:0] SIG_ADDR0 = 12'h030;
  localparam logic [7:0]  ERASED    = 8'hff;

  // timing
  localparam int CLK_NS        = 40;
  localparam int WRITE_NS      = 1500000;
  localparam int WRITE_MAX_NS  = 2000000;
  localparam int ERASE_NS      = 10000000;
  localparam int BUSY_MAX_NS   = 1000;
  localparam int WRITE_CYC     = WRITE_NS / CLK_NS;
  localparam int WRITE_MAX_CYC = WRITE_MAX_NS / CLK_NS;
  localparam int ERASE_CYC     = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_MAX_CYC  = BUSY_MAX_NS / CLK_NS;
  localparam int READ_MAX_CYC  = 48;
  localparam int FIFO_DEPTH    = 16;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h1,
    ENG_BUSY = 2'h2
  } fpli_eng_type;

endpackage

// File: core/fpli_core.sv
// flash program and lock interface: pin decode, write queue, self-timed writer
// assumes all pins are asynchronous and held stable for many clocks
`timescale 1ns/1ps

module fpli_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = fpli_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fpli_fifo_state_type;

  fpli_fifo_state_type s, n;
  logic [WIDTH-1:0] store [DEPTH];
  logic push, pop;

  assign inReady  = s.cnt != (AW+1)'(DEPTH);
  assign outValid = s.cnt != '0;
  assign outData  = store[s.rp];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    n = s;
    if (push) n.wp = s.wp + 1'b1;
    if (pop) n.rp = s.rp + 1'b1;
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s <= '0;
    else s <= n;
  end

  always_ff @(posedge clk) begin
    if (push) store[s.wp] <= inData;
  end
endmodule // fpli_fifo

////////////////////////////////////////////////////////////////////////////////

module fpli_core #(
  parameter int         ADDR_W    = fpli_pkg::ADDR_W_DEF,
  parameter int         WRITE_CYC = fpli_pkg::WRITE_CYC,
  parameter int         ERASE_CYC = fpli_pkg::ERASE_CYC,
  parameter logic [7:0] SIG_MAKER = 8'h5a,  // arbitrary value
  parameter logic [7:0] SIG_PART  = 8'ha5,  // arbitrary value
  parameter logic [7:0] SIG_VPP   = 8'hff   // programming voltage code
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // programming controls
  input  wire logic              rstPin,
  input  wire logic              codeFetchStrobeN,
  input  wire logic              programStrobeN,
  input  wire logic              externalFetchStrapN,
  input  wire logic              port2Bit6,
  input  wire logic              port2Bit7,
  input  wire logic              port3Bit6,
  input  wire logic              port3Bit7,
  // address (port one low byte, port two high bits) and data port
  input  wire logic [ADDR_W-1:0] addressIn,
  input  wire logic [7:0]        port0In,
  output logic [7:0]             port0Out,
  output logic                   port0OeN,
  // ready/busy pin
  output logic                   port3Bit4,
  // protection effects seen by the processor core
  output logic                   codeTableReadBlock,
  output logic                   externalExecDisable,
  output logic                   programInhibit,
  output logic                   externalFetchEnable
);
  localparam int PIN_W = fpli_pkg::PIN_FIXED + ADDR_W;
  localparam int ENT_W = 2 + ADDR_W + 8;
  localparam int EW    = $clog2(ERASE_CYC + 1);
  localparam int WW    = $clog2(WRITE_CYC + 1);

  typedef struct packed {
    logic [PIN_W-1:0]     sync1;
    logic [PIN_W-1:0]     sync2;
    logic                 progPrev;
    logic [EW-1:0]        eraseCnt;
    logic                 lock1;
    logic                 lock2;
    logic                 lock3;
    logic                 strapLatchN;
    logic [ADDR_W-1:0]    lastAddr;
    logic [7:0]           lastData;
    fpli_pkg::fpli_eng_type eng;
    logic [WW-1:0]        wCnt;
    logic [ENT_W-1:0]     cur;
    logic [7:0]           port0Out;
    logic                 port0OeN;
    logic                 busyN;
    logic                 tableBlock;
    logic                 execDisable;
    logic                 progInhibit;
    logic                 fetchExtEn;
  } fpli_core_state_type;

  fpli_core_state_type s, n;
  logic [7:0] codeMem [2**ADDR_W];

  logic              rstP, fetchN, progN, strapN, progRise, inProg;
  logic [3:0]        sel;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        dIn, rdByte;
  logic              push, erasePulse, commit, fifoReady, fifoValid;
  logic [ENT_W-1:0]  pushEnt, fifoOut;
  logic [1:0]        curKind;
  logic [ADDR_W-1:0] curAddr;
  logic [7:0]        curData;

  // mode decode only counts while reset pin is high and code fetch strobe low
  function automatic logic modeIs(input logic gate, input logic [3:0] s4, input logic [3:0] code);
    modeIs = gate && (s4 == code);
  endfunction

  assign rstP    = s.sync2[fpli_pkg::PIN_RST];
  assign fetchN  = s.sync2[fpli_pkg::PIN_FETCH];
  assign progN   = s.sync2[fpli_pkg::PIN_PROGRAM_STROBE_N];
  assign strapN  = s.sync2[fpli_pkg::PIN_STRAP];
  assign sel     = s.sync2[fpli_pkg::PIN_P26:fpli_pkg::PIN_P37];
  assign addr    = s.sync2[fpli_pkg::PIN_ADDR +: ADDR_W];
  assign dIn     = s.sync2[fpli_pkg::PIN_ADDR + ADDR_W +: 8];
  assign inProg  = rstP && !fetchN;
  assign progRise = progN && !s.progPrev;
  assign rdByte  = codeMem[addr];
  assign {curKind, curAddr, curData} = s.cur;

  // the queue decouples strobe capture from the slow self-timed writer
  fpli_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (fpli_pkg::FIFO_DEPTH)
  ) u_queue (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (push),
    .inData   (pushEnt),
    .inReady  (fifoReady),
    .outValid (fifoValid),
    .outData  (fifoOut),
    .outReady (s.eng == fpli_pkg::ENG_IDLE)
  );

  always_comb begin
    n = s;
    push = 1'b0;
    pushEnt = '0;
    erasePulse = 1'b0;
    commit = 1'b0;
    // two flops per pin; skew across address bits is covered by long setup
    n.sync1 = {port0In, addressIn, rstPin, codeFetchStrobeN, programStrobeN,
               externalFetchStrapN, port2Bit6, port2Bit7, port3Bit6, port3Bit7};
    n.sync2 = s.sync1;
    // a rise only counts once the strobe was seen low inside programming mode, so no false edge after reset
    n.progPrev = progN || !inProg;

    // strobe release queues a byte or lock write
    if (inProg && progRise && fifoReady) begin
      if (modeIs(inProg, sel, fpli_pkg::SEL_WRITE_CODE) && !s.lock1) begin
        push = 1'b1;
        pushEnt = {fpli_pkg::KIND_CODE, addr, dIn};
        n.lastAddr = addr;
        n.lastData = dIn;
      end else if (modeIs(inProg, sel, fpli_pkg::SEL_LOCK_ONE)) begin
        push = 1'b1;
        pushEnt = {fpli_pkg::KIND_LOCK1, addr, dIn};
      end else if (modeIs(inProg, sel, fpli_pkg::SEL_LOCK_TWO)) begin
        push = 1'b1;
        pushEnt = {fpli_pkg::KIND_LOCK2, addr, dIn};
      end else if (modeIs(inProg, sel, fpli_pkg::SEL_LOCK_THREE)) begin
        push = 1'b1;
        pushEnt = {fpli_pkg::KIND_LOCK3, addr, dIn};
      end
    end

    // erase fires once when the strobe has been low long enough
    if (modeIs(inProg, sel, fpli_pkg::SEL_ERASE) && !progN) begin
      if (s.eraseCnt != EW'(ERASE_CYC)) n.eraseCnt = s.eraseCnt + 1'b1;
      erasePulse = s.eraseCnt == EW'(ERASE_CYC - 1);
    end else begin
      n.eraseCnt = '0;
    end
    if (erasePulse) begin
      n.lock1 = 1'b0;
      n.lock2 = 1'b0;
      n.lock3 = 1'b0;
    end

    // self-timed writer
    case (s.eng)
      fpli_pkg::ENG_IDLE: begin
        if (fifoValid) begin
          n.cur = fifoOut;
          n.wCnt = '0;
          n.eng = fpli_pkg::ENG_BUSY;
        end
      end
      fpli_pkg::ENG_BUSY: begin
        if (s.wCnt == WW'(WRITE_CYC - 1)) begin
          commit = 1'b1;
          n.eng = fpli_pkg::ENG_IDLE;
          if (curKind == fpli_pkg::KIND_LOCK1) n.lock1 = 1'b1;
          if (curKind == fpli_pkg::KIND_LOCK2) n.lock2 = 1'b1;
          if (curKind == fpli_pkg::KIND_LOCK3) n.lock3 = 1'b1;
        end else begin
          n.wCnt = s.wCnt + 1'b1;
        end
      end
      default: n.eng = fpli_pkg::ENG_IDLE;
    endcase
    // pin goes ready only when nothing is queued or writing
    n.busyN = !(push || fifoValid || n.eng == fpli_pkg::ENG_BUSY);

    // strap is caught while reset pin is high and lock one is set, not at the async reset
    if (rstP && s.lock1) n.strapLatchN = strapN;
    n.tableBlock  = s.lock1;
    n.progInhibit = s.lock1;
    n.execDisable = s.lock1 && s.lock2 && s.lock3;
    n.fetchExtEn  = !(s.lock1 ? s.strapLatchN : strapN) && !n.execDisable;

    // reads: lock bits have no read path of their own
    n.port0OeN = 1'b1;
    n.port0Out = fpli_pkg::ERASED;
    if (progN && modeIs(inProg, sel, fpli_pkg::SEL_READ_CODE) && !s.lock1 && !s.lock2) begin
      n.port0OeN = 1'b0;
      n.port0Out = rdByte;
      if (!s.busyN && addr == s.lastAddr) n.port0Out[7] = ~s.lastData[7];
    end else if (progN && modeIs(inProg, sel, fpli_pkg::SEL_SIGNATURE)) begin
      n.port0OeN = 1'b0;
      if (addr == ADDR_W'(fpli_pkg::SIG_ADDR0)) n.port0Out = SIG_MAKER;
      else if (addr == ADDR_W'(fpli_pkg::SIG_ADDR0 + 12'h001)) n.port0Out = SIG_PART;
      else if (addr == ADDR_W'(fpli_pkg::SIG_ADDR0 + 12'h002)) n.port0Out = SIG_VPP;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.eng <= fpli_pkg::ENG_IDLE;
      s.strapLatchN <= 1'b1;
      s.port0OeN <= 1'b1;
      s.port0Out <= 8'hff;
      s.busyN <= 1'b1;
      s.progPrev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // flash cells only clear bits on a write; erase sets them all
  always_ff @(posedge clk) begin
    if (erasePulse) begin
      for (int i = 0; i < 2**ADDR_W; i++) codeMem[i] <= fpli_pkg::ERASED;
    end else if (commit && curKind == fpli_pkg::KIND_CODE) begin
      codeMem[curAddr] <= codeMem[curAddr] & curData;
    end
  end

  assign port0Out            = s.port0Out;
  assign port0OeN            = s.port0OeN;
  assign port3Bit4           = s.busyN;
  assign codeTableReadBlock  = s.tableBlock;
  assign externalExecDisable = s.execDisable;
  assign programInhibit      = s.progInhibit;
  assign externalFetchEnable = s.fetchExtEn;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_code_strobe;
    inProg && progRise && fifoReady && sel == fpli_pkg::SEL_WRITE_CODE && !s.lock1;
  endsequence
  sequence s_poll_read;
    progN && inProg && sel == fpli_pkg::SEL_READ_CODE && !s.lock1 && !s.lock2 && !s.busyN && addr == s.lastAddr;
  endsequence

  property p_busy_fast;
    s_code_strobe |=> !port3Bit4 [*2];
  endproperty
  a_busy_fast: assert property (p_busy_fast) else $error("busy not shown after strobe");
  property p_write_bound;
    s.eng == fpli_pkg::ENG_BUSY |-> s.wCnt < WW'(WRITE_CYC);
  endproperty
  a_write_bound: assert property (p_write_bound) else $error("write exceeds its cycle");
  property p_poll;
    s_poll_read |=> port0Out[7] == ~$past(s.lastData[7]) && !port0OeN;
  endproperty
  a_poll: assert property (p_poll) else $error("polling bit not inverted");
  property p_verify_lock;
    (s.lock1 || s.lock2) && sel == fpli_pkg::SEL_READ_CODE |=> port0OeN;
  endproperty
  a_verify_lock: assert property (p_verify_lock) else $error("verify read while locked");
  property p_mode2;
    s.lock1 |=> codeTableReadBlock && programInhibit;
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode two limits missing");
  property p_mode4;
    s.lock1 && s.lock2 && s.lock3 |=> externalExecDisable && !externalFetchEnable;
  endproperty
  a_mode4: assert property (p_mode4) else $error("external execution not disabled");
  property p_erase;
    erasePulse |=> codeMem[0] == fpli_pkg::ERASED && !s.lock1 && !s.lock2;
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not set ones");
  property p_rst_gate;
    !rstP |-> !push && !erasePulse;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("mode taken without reset pin");
  property p_ready_after;
    commit && !fifoValid && !push |=> port3Bit4;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("ready not restored");
endmodule // fpli_core

// File: test/fpli_program_strobe_n_model.sv
// programmer model: drives the programming pins and the pulled-up data port
// assumes the bench calls its tasks one at a time from one process
`timescale 1ns/1ps

module fpli_program_strobe_n_model #(
  parameter int ERASE_CYC = 20
) (
  // clock
  input  wire logic        clk,
  // device side
  input  wire logic [7:0]  port0Out,
  input  wire logic        port0OeN,
  input  wire logic        port3Bit4,
  // pins towards the device
  output logic             rstPin,
  output logic             codeFetchStrobeN,
  output logic             programStrobeN,
  output logic             externalFetchStrapN,
  output logic [3:0]       modeSel,
  output logic [11:0]      addr,
  output logic [7:0]       port0Wire
);
  logic       drvOn;
  logic [7:0] drvVal;

  // external pull-ups: a released port reads high
  assign port0Wire = !port0OeN ? port0Out : (drvOn ? drvVal : 8'hff);

  initial begin
    rstPin              = 1'b1;
    codeFetchStrobeN    = 1'b0;
    programStrobeN      = 1'b1;
    externalFetchStrapN = 1'b1;
    modeSel             = fpli_pkg::SEL_READ_CODE;
    addr                = 12'h000;
    drvOn               = 1'b0;
    drvVal              = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////

  task automatic set_pins(input logic rst, input logic strap);
    @(posedge clk) #2;
    rstPin = rst;
    externalFetchStrapN = strap;
    repeat (8) @(posedge clk);
  endtask

  // lat is -1 when busy never showed; address, data and mode set 48 cycles before the strobe, data and mode held 49 cycles past it when polling
  task automatic write_op(input logic [3:0] m, input logic [11:0] a, input logic [7:0] d, input bit poll,
                          output int lat, output int lowCnt, output logic [7:0] pollVal);
    lat = -1;
    lowCnt = 0;
    pollVal = 8'h00;
    @(posedge clk) #2;
    addr = a;
    drvVal = d;
    drvOn = 1'b1;
    modeSel = m;
    repeat (48) @(posedge clk);
    #2 programStrobeN = 1'b0;              // one pulse per byte
    repeat (25) @(posedge clk);
    #2 programStrobeN = 1'b1;
    for (int i = 1; i <= 100; i++) begin
      @(posedge clk) #2;
      if (poll && i == 49) begin
        drvOn = 1'b0;
        modeSel = fpli_pkg::SEL_READ_CODE;
      end
      if (port3Bit4 === 1'b0) begin
        if (lat < 0) lat = i;
        lowCnt++;
        if (lowCnt == 60) pollVal = port0Wire;
      end
    end
    drvOn = 1'b0;                          // hold ran 100 cycles
  endtask

  task automatic erase();
    @(posedge clk) #2;
    modeSel = fpli_pkg::SEL_ERASE;
    repeat (4) @(posedge clk);
    #2 programStrobeN = 1'b0;
    repeat (ERASE_CYC + 10) @(posedge clk);
    #2 programStrobeN = 1'b1;
    repeat (8) @(posedge clk);
    #2 modeSel = fpli_pkg::SEL_READ_CODE;
  endtask

  task automatic read_op(input logic [3:0] m, input logic [11:0] a, output logic [7:0] v, output logic oeN);
    @(posedge clk) #2;
    drvOn = 1'b0;
    modeSel = m;
    addr = a;
    repeat (48) @(posedge clk);
    #2 v = port0Wire;
    oeN = port0OeN;
  endtask

endmodule // fpli_program_strobe_n_model

// File: test/fpli_testbench.sv
// self-checking bench of the flash program and lock interface
// assumes the programmer model of fpli_program_strobe_n_model and short write and erase counts
`timescale 1ns/1ps

module testbench;
  localparam int         WCYC  = 80;
  localparam int         ECYC  = 20;
  localparam logic [7:0] SIG_A = 8'h3c;  // arbitrary value
  localparam logic [7:0] SIG_B = 8'hc3;  // arbitrary value
  localparam logic [7:0] SIG_C = 8'hff;

  typedef struct packed { logic [11:0] a; logic [7:0] d; logic [7:0] e; } fpli_row_type;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rstPin, codeFetchStrobeN, programStrobeN, externalFetchStrapN;
  logic [3:0] modeSel;
  logic [11:0] addr;
  logic [7:0] port0Wire, port0Out, v, pv;
  logic port0OeN, port3Bit4, oe;
  logic codeTableReadBlock, externalExecDisable, programInhibit, externalFetchEnable;
  int errorCnt = 0;
  int nChecks = 0;
  int cycles = 0;
  int lat, lowCnt;
  logic [7:0] sigs [4] = '{SIG_A, SIG_B, SIG_C, 8'hff};
  // every row writes a blank byte once, so no erase is needed in between
  fpli_row_type rows [6] = '{'{12'h000, 8'h00, 8'h00}, '{12'hfff, 8'h7f, 8'h7f}, '{12'h5a5, 8'h80, 8'h80},
                             '{12'h123, 8'hf0, 8'hf0}, '{12'h456, 8'h3c, 8'h3c}, '{12'h030, 8'ha5, 8'ha5}};

  fpli_core #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC), .SIG_MAKER(SIG_A), .SIG_PART(SIG_B), .SIG_VPP(SIG_C)) dut (
    .clk(clk), .nrst(nrst), .rstPin(rstPin), .codeFetchStrobeN(codeFetchStrobeN),
    .programStrobeN(programStrobeN), .externalFetchStrapN(externalFetchStrapN),
    .port2Bit6(modeSel[3]), .port2Bit7(modeSel[2]), .port3Bit6(modeSel[1]), .port3Bit7(modeSel[0]),
    .addressIn(addr), .port0In(port0Wire), .port0Out(port0Out), .port0OeN(port0OeN), .port3Bit4(port3Bit4),
    .codeTableReadBlock(codeTableReadBlock), .externalExecDisable(externalExecDisable),
    .programInhibit(programInhibit), .externalFetchEnable(externalFetchEnable));

  fpli_program_strobe_n_model #(.ERASE_CYC(ECYC)) program_strobe_n (
    .clk(clk), .port0Out(port0Out), .port0OeN(port0OeN), .port3Bit4(port3Bit4), .rstPin(rstPin),
    .codeFetchStrobeN(codeFetchStrobeN), .programStrobeN(programStrobeN),
    .externalFetchStrapN(externalFetchStrapN), .modeSel(modeSel), .addr(addr), .port0Wire(port0Wire));

  //////////////////////////////////////////////////////////////////////////////

  always #20 clk = ~clk;

  // the whole run needs about 2800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    if (errorCnt == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////

  initial begin
    repeat (12) @(posedge clk);
    #2 nrst = 1'b1;
    repeat (4) @(posedge clk);
    program_strobe_n.erase();
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h777, v, oe);
    chk("blank byte", 8'hff, v);
    for (int i = 0; i < 6; i++) begin
      program_strobe_n.write_op(fpli_pkg::SEL_WRITE_CODE, rows[i].a, rows[i].d, 1'b1, lat, lowCnt, pv);
      chk("busy latency", 1, 16'(lat > 0 && lat <= fpli_pkg::BUSY_MAX_CYC));
      chk("busy length", 16'(WCYC + 1), 16'(lowCnt));
      chk("poll bit", {15'h0, ~rows[i].d[7]}, {15'h0, pv[7]});
      program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, rows[i].a, v, oe);
      chk("read data", rows[i].e, v);
      chk("read drive", 0, oe);
    end
    for (int i = 0; i < 4; i++) begin
      program_strobe_n.read_op(fpli_pkg::SEL_SIGNATURE, fpli_pkg::SIG_ADDR0 + 12'(i), v, oe);
      chk("signature", sigs[i], v);
    end
    program_strobe_n.set_pins(1'b0, 1'b1);
    program_strobe_n.write_op(fpli_pkg::SEL_WRITE_CODE, 12'h777, 8'h00, 1'b0, lat, lowCnt, pv);
    chk("ignored busy", 16'hffff, 16'(lat));
    program_strobe_n.set_pins(1'b1, 1'b0);
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h777, v, oe);
    chk("ignored data", 8'hff, v);
    program_strobe_n.write_op(fpli_pkg::SEL_LOCK_ONE, 12'h000, 8'hff, 1'b0, lat, lowCnt, pv);
    chk("lock busy", 16'(WCYC + 1), 16'(lowCnt));
    chk("mode two", 3'b110, {codeTableReadBlock, programInhibit, externalExecDisable});
    chk("strap latch", 1, externalFetchEnable);
    program_strobe_n.write_op(fpli_pkg::SEL_WRITE_CODE, 12'h777, 8'h00, 1'b0, lat, lowCnt, pv);
    chk("inhibited write", 16'hffff, 16'(lat));
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h777, v, oe);
    chk("verify refused", 9'h1ff, {oe, v});
    program_strobe_n.set_pins(1'b0, 1'b1);
    chk("strap held", 1, externalFetchEnable);
    program_strobe_n.set_pins(1'b1, 1'b0);
    program_strobe_n.write_op(fpli_pkg::SEL_LOCK_TWO, 12'h000, 8'hff, 1'b0, lat, lowCnt, pv);
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h000, v, oe);
    chk("mode three", 4'b1101, {codeTableReadBlock, programInhibit, externalExecDisable, oe});
    program_strobe_n.write_op(fpli_pkg::SEL_LOCK_THREE, 12'h000, 8'hff, 1'b0, lat, lowCnt, pv);
    chk("mode four", 4'b1110,
        {codeTableReadBlock, programInhibit, externalExecDisable, externalFetchEnable});
    program_strobe_n.erase();
    chk("erase unlocks", 3'b000, {codeTableReadBlock, programInhibit, externalExecDisable});
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h5a5, v, oe);
    chk("erased byte", 9'h0ff, {oe, v});
    // reset in mid-read: the port must be released at once
    nrst = 1'b0;
    #5 chk("reset outputs", 11'h7ff, {port0OeN, port3Bit4, port0Out, ~programInhibit});
    @(posedge clk) #2 nrst = 1'b1;
    program_strobe_n.read_op(fpli_pkg::SEL_READ_CODE, 12'h5a5, v, oe);
    chk("reread after reset", 9'h0ff, {oe, v});
    chk("ready after reset", 1, port3Bit4);
    end_sim();
  end

endmodule // testbench
